//--- verilog/sctl_regs.svh
// Purpose: Offsets, field positions, reset values and timing for the
//          system control register bank.
// Assumes: 100 MHz configuration clock.
// Notes:   Definitions only.
`ifndef SCTL_REGS_SVH
`define SCTL_REGS_SVH

// ****************************************
// Register address and reset image
// ****************************************
`define SCTL_OFFSET        8'h80
`define SCTL_RESET_VALUE   32'h08449060

// ****************************************
// Field positions
// ****************************************
`define SCTL_B_PROT_DIS    21
`define SCTL_B_RSVD_HI     16
`define SCTL_B_BURST_DN    15
`define SCTL_B_BURST_UP    14
`define SCTL_B_ACTIVITY    13
`define SCTL_B_ONE         12
`define SCTL_B_STREAM      11
`define SCTL_B_UP_SETTLE   10
`define SCTL_B_DN_SETTLE   9
`define SCTL_B_PROBE       8
`define SCTL_B_ZERO_HI     7
`define SCTL_B_LOW_PWR     6
`define SCTL_B_LOCK        5
`define SCTL_B_PAR_EN      4
`define SCTL_B_ZERO_LO     3
`define SCTL_B_LEGACY_5V   2
`define SCTL_B_CLOCKS_ALWAYS_ON     1
`define SCTL_B_WAKE_RING_PIN_SELECT       0

// ****************************************
// Byte lanes holding writable fields
// ****************************************
`define SCTL_LANE_LO       0
`define SCTL_LANE_MID      1
`define SCTL_LANE_HI       2

// ****************************************
// Power switch settling delay
// ****************************************
`define SCTL_SETTLE_NS     20000
`define SCTL_CLK_NS        10
`define SCTL_SETTLE_CYC    ((`SCTL_SETTLE_NS + `SCTL_CLK_NS - 1) / `SCTL_CLK_NS)
`define SCTL_CNT_W         12

`endif

//--- verilog/sctl_pkg.sv
// Purpose: Types shared by the system control bank.
// Assumes: Nothing beyond the register header.
// Notes:   Constants live in sctl_regs.svh.
`default_nettype none
`include "sctl_regs.svh"
package sctl_pkg;
  // Power switch sequencing phases
  typedef enum logic [1:0] {
    SCTL_PWR_IDLE,
    SCTL_PWR_STREAM,
    SCTL_PWR_SETTLE
  } sctl_pwr_e;
  typedef logic [`SCTL_CNT_W-1:0] sctl_cnt_t;
endpackage
`default_nettype wire

//--- verilog/sctl_sync.sv
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Idle level of every bit is high.
// Notes:   First stage is read only by the second.
`timescale 1ns/100ps
`default_nettype none
module sctl_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // Reset to idle so a released reset does not look like an assertion
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '1;
      q      <= '1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

//--- verilog/sctl_pwr_seq.sv
// Purpose: Tracks the serial power stream and its settling delay.
// Assumes: Request and done are one-cycle pulses on clk.
// Notes:   Settling flags are context bits with their own clear.
`timescale 1ns/100ps
`default_nettype none
`include "sctl_regs.svh"
module sctl_pwr_seq (
  // Clock and resets
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ctx_clr,
  // Switch events
  input  wire logic pwr_change_req,
  input  wire logic stream_done,
  input  wire logic stream_is_up,
  // Status
  output var  logic power_stream_busy,
  output var  logic power_up_settling,
  output var  logic power_down_settling
);
  import sctl_pkg::*;
  localparam sctl_cnt_t SETTLE = sctl_cnt_t'(`SCTL_SETTLE_CYC);
  sctl_pwr_e state_r;
  sctl_cnt_t cnt_r;
  sctl_cnt_t since_end_r;
  logic      expire;

  assign expire = (state_r == SCTL_PWR_SETTLE) && (cnt_r == sctl_cnt_t'(1));

  // Phase sequencer; a new request restarts the stream
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= SCTL_PWR_IDLE;
    end else if (pwr_change_req) begin
      state_r <= SCTL_PWR_STREAM;
    end else begin
      unique case (state_r)
        SCTL_PWR_IDLE: begin
          state_r <= SCTL_PWR_IDLE;
        end
        SCTL_PWR_STREAM: begin
          if (stream_done) begin
            state_r <= SCTL_PWR_SETTLE;
          end
        end
        SCTL_PWR_SETTLE: begin
          if (expire) begin
            state_r <= SCTL_PWR_IDLE;
          end
        end
      endcase
    end
  end

  // Settling counter, loaded when the stream ends
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (state_r == SCTL_PWR_STREAM && stream_done) begin
      cnt_r <= SETTLE;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - sctl_cnt_t'(1);
    end
  end

  // Busy from request to end of delay; global reset only
  always_ff @(posedge clk) begin
    if (rst) begin
      power_stream_busy <= 1'b0;
    end else begin
      power_stream_busy <= pwr_change_req ||
        (state_r == SCTL_PWR_STREAM) || (state_r == SCTL_PWR_SETTLE && !expire);
    end
  end

  // Direction flags, set at stream end and dropped at expiry
  always_ff @(posedge clk) begin
    if (rst || ctx_clr || expire || pwr_change_req) begin
      power_up_settling   <= 1'b0;
      power_down_settling <= 1'b0;
    end else if (state_r == SCTL_PWR_STREAM && stream_done) begin
      power_up_settling   <= stream_is_up;
      power_down_settling <= !stream_is_up;
    end
  end

  // Cycles since the stream ended; lets the checks count a long delay
  always_ff @(posedge clk) begin
    if (rst || pwr_change_req) begin
      since_end_r <= '0;
    end else if (state_r == SCTL_PWR_STREAM && stream_done) begin
      since_end_r <= sctl_cnt_t'(1);
    end else if (since_end_r == SETTLE) begin
      since_end_r <= '0;
    end else if (since_end_r != '0) begin
      since_end_r <= since_end_r + sctl_cnt_t'(1);
    end
  end

  sequence s_stream_end;
    state_r == SCTL_PWR_STREAM && stream_done && !pwr_change_req;
  endsequence
  sequence s_settled;
    !power_up_settling && !power_down_settling && !power_stream_busy;
  endsequence

  a_busy_on_req: assert property (@(posedge clk) disable iff (rst)
    pwr_change_req |=> power_stream_busy)
    else $error("stream busy not raised on request");
  a_up_flag_set: assert property (@(posedge clk) disable iff (rst)
    s_stream_end and stream_is_up && !ctx_clr |=> power_up_settling)
    else $error("power-up settling flag not set");
  a_busy_holds: assert property (@(posedge clk) disable iff (rst)
    since_end_r != '0 && since_end_r != SETTLE && !pwr_change_req |=> power_stream_busy)
    else $error("stream busy dropped before settling ended");
  a_settle_ends: assert property (@(posedge clk) disable iff (rst)
    since_end_r == SETTLE && !pwr_change_req |=> s_settled)
    else $error("settling did not finish on time");
endmodule
`default_nettype wire

//--- verilog/sctl_top.sv
// Purpose: System control register, low 22 bits, in configuration space.
// Assumes: clk is the configuration clock; rst is the global reset.
// Notes:   Bits 31-22 are outside this block and read as zero.
`timescale 1ns/100ps
`default_nettype none
`include "sctl_regs.svh"
module sctl_top (
  // Clock and global reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Bus reset pin and wake enable
  input  wire logic        pci_bus_reset_n,
  input  wire logic        pme_enable,
  // Configuration access to function 0
  input  wire logic [7:0]  cfg_addr,
  input  wire logic        cfg_rd,
  input  wire logic        cfg_wr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output var  logic [31:0] cfg_rdata,
  // Hardware status sources
  input  wire logic        card_access,
  input  wire logic        pwr_change_req,
  input  wire logic        stream_done,
  input  wire logic        stream_is_up,
  input  wire logic        probe_active,
  input  wire logic        legacy_5v_sel,
  input  wire logic        card_parity_err,
  // Wake and ring sources
  input  wire logic        pme_event,
  input  wire logic        ring_indicate_output,
  input  wire logic        ring_output_enable,
  // Control outputs
  output var  logic        card_supply_protect_disable,
  output var  logic        read_burst_downstream_en,
  output var  logic        read_burst_upstream_en,
  output var  logic        low_power_mode_en,
  output var  logic        id_regs_write_lock,
  output var  logic        card_parity_to_syserr_en,
  output var  logic        clocks_always_on,
  output var  logic        wake_ring_pin_select,
  output var  logic        card_parity_syserr,
  // Shared wake/ring pin
  output var  logic        wake_ring_pin_o,
  output var  logic        wake_ring_pin_oe_n
);
  import sctl_pkg::*;

  localparam logic [31:0] RV = `SCTL_RESET_VALUE;

  // ****************************************
  // Byte-lane decode
  // ****************************************
  function automatic logic lane_wr(input logic [3:0] be, input int lane);
    lane_wr = be[lane];
  endfunction

  logic        hit;
  logic        wr_hit;
  logic        rd_hit;
  logic        wr_lo;
  logic        wr_mid;
  logic        wr_hi;
  logic        bus_rst_n_s;
  logic        ctx_clr;
  logic [4:0]  rsvd_hi_r;
  logic        socket_activity_flag;
  logic        card_probe_busy;
  logic        legacy_supply_level;
  logic        power_stream_busy;
  logic        power_up_settling;
  logic        power_down_settling;
  logic [31:0] sctl_value;

  assign hit    = (cfg_addr == `SCTL_OFFSET);
  assign wr_hit = hit && cfg_wr;
  assign rd_hit = hit && cfg_rd;
  assign wr_lo  = wr_hit && lane_wr(cfg_be, `SCTL_LANE_LO);
  assign wr_mid = wr_hit && lane_wr(cfg_be, `SCTL_LANE_MID);
  assign wr_hi  = wr_hit && lane_wr(cfg_be, `SCTL_LANE_HI);

  // ****************************************
  // Bus reset pin crossing
  // ****************************************
  sctl_sync #(.W(1)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (pci_bus_reset_n),
    .q   (bus_rst_n_s)
  );

  // Context bits survive bus reset only while wake events are armed
  assign ctx_clr = !bus_rst_n_s && !pme_enable;

  // ****************************************
  // Writable fields, loaded with reset values by global reset only
  // ****************************************
  // Upper lane: protection and reserved bits written back as given
  always_ff @(posedge clk) begin
    if (rst) begin
      card_supply_protect_disable <= RV[`SCTL_B_PROT_DIS];
      rsvd_hi_r                   <= RV[`SCTL_B_RSVD_HI +: 5];
    end else if (wr_hi) begin
      card_supply_protect_disable <= cfg_wdata[`SCTL_B_PROT_DIS];
      rsvd_hi_r                   <= cfg_wdata[`SCTL_B_RSVD_HI +: 5];
    end
  end

  // Middle lane: read burst enables
  always_ff @(posedge clk) begin
    if (rst) begin
      read_burst_downstream_en <= RV[`SCTL_B_BURST_DN];
      read_burst_upstream_en   <= RV[`SCTL_B_BURST_UP];
    end else if (wr_mid) begin
      read_burst_downstream_en <= cfg_wdata[`SCTL_B_BURST_DN];
      read_burst_upstream_en   <= cfg_wdata[`SCTL_B_BURST_UP];
    end
  end

  // Low lane: power savings, id lock, parity, clocks, pin select
  always_ff @(posedge clk) begin
    if (rst) begin
      low_power_mode_en        <= RV[`SCTL_B_LOW_PWR];
      id_regs_write_lock       <= RV[`SCTL_B_LOCK];
      card_parity_to_syserr_en <= RV[`SCTL_B_PAR_EN];
      clocks_always_on         <= RV[`SCTL_B_CLOCKS_ALWAYS_ON];
      wake_ring_pin_select     <= RV[`SCTL_B_WAKE_RING_PIN_SELECT];
    end else if (wr_lo) begin
      low_power_mode_en        <= cfg_wdata[`SCTL_B_LOW_PWR];
      id_regs_write_lock       <= cfg_wdata[`SCTL_B_LOCK];
      card_parity_to_syserr_en <= cfg_wdata[`SCTL_B_PAR_EN];
      clocks_always_on         <= cfg_wdata[`SCTL_B_CLOCKS_ALWAYS_ON];
      wake_ring_pin_select     <= cfg_wdata[`SCTL_B_WAKE_RING_PIN_SELECT];
    end
  end

  // ****************************************
  // Status fields
  // ****************************************
  // Activity: an access in the read cycle wins so no access goes unseen
  always_ff @(posedge clk) begin
    if (rst) begin
      socket_activity_flag <= 1'b0;
    end else if (card_access) begin
      socket_activity_flag <= 1'b1;
    end else if (rd_hit) begin
      socket_activity_flag <= 1'b0;
    end
  end

  // Interrogation mirror, a context bit
  always_ff @(posedge clk) begin
    if (rst || ctx_clr) begin
      card_probe_busy <= 1'b0;
    end else begin
      card_probe_busy <= probe_active;
    end
  end

  // Legacy supply level follows the socket power logic
  always_ff @(posedge clk) begin
    if (rst) begin
      legacy_supply_level <= 1'b0;
    end else begin
      legacy_supply_level <= legacy_5v_sel;
    end
  end

  sctl_pwr_seq u_pwr (
    .clk                 (clk),
    .rst                 (rst),
    .ctx_clr             (ctx_clr),
    .pwr_change_req      (pwr_change_req),
    .stream_done         (stream_done),
    .stream_is_up        (stream_is_up),
    .power_stream_busy   (power_stream_busy),
    .power_up_settling   (power_up_settling),
    .power_down_settling (power_down_settling)
  );

  // ****************************************
  // Read path
  // ****************************************
  // Fixed bits come from constants, so writes cannot reach them
  always_comb begin
    sctl_value                          = '0;
    sctl_value[`SCTL_B_PROT_DIS]        = card_supply_protect_disable;
    sctl_value[`SCTL_B_RSVD_HI +: 5]    = rsvd_hi_r;
    sctl_value[`SCTL_B_BURST_DN]        = read_burst_downstream_en;
    sctl_value[`SCTL_B_BURST_UP]        = read_burst_upstream_en;
    sctl_value[`SCTL_B_ACTIVITY]        = socket_activity_flag;
    sctl_value[`SCTL_B_ONE]             = 1'b1;
    sctl_value[`SCTL_B_STREAM]          = power_stream_busy;
    sctl_value[`SCTL_B_UP_SETTLE]       = power_up_settling;
    sctl_value[`SCTL_B_DN_SETTLE]       = power_down_settling;
    sctl_value[`SCTL_B_PROBE]           = card_probe_busy;
    sctl_value[`SCTL_B_ZERO_HI]         = 1'b0;
    sctl_value[`SCTL_B_LOW_PWR]         = low_power_mode_en;
    sctl_value[`SCTL_B_LOCK]            = id_regs_write_lock;
    sctl_value[`SCTL_B_PAR_EN]          = card_parity_to_syserr_en;
    sctl_value[`SCTL_B_ZERO_LO]         = 1'b0;
    sctl_value[`SCTL_B_LEGACY_5V]       = legacy_supply_level;
    sctl_value[`SCTL_B_CLOCKS_ALWAYS_ON]         = clocks_always_on;
    sctl_value[`SCTL_B_WAKE_RING_PIN_SELECT]           = wake_ring_pin_select;
  end

  // Read data registered one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_rdata <= '0;
    end else begin
      cfg_rdata <= rd_hit ? sctl_value : '0;
    end
  end

  // ****************************************
  // Parity reporting and shared pin
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      card_parity_syserr <= 1'b0;
    end else begin
      card_parity_syserr <= card_parity_err && card_parity_to_syserr_en;
    end
  end

  // Pin floats when neither the wake route nor the ring enable is set
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_ring_pin_o    <= 1'b0;
      wake_ring_pin_oe_n <= 1'b1;
    end else begin
      wake_ring_pin_o    <= wake_ring_pin_select ? pme_event
                                                 : ring_indicate_output;
      wake_ring_pin_oe_n <= !(wake_ring_pin_select || ring_output_enable);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_act_set: assert property (@(posedge clk) disable iff (rst)
    card_access |=> socket_activity_flag)
    else $error("activity flag not set by access");
  a_act_read_clr: assert property (@(posedge clk) disable iff (rst)
    rd_hit && !card_access |=> !socket_activity_flag)
    else $error("activity flag not cleared by read");
  a_fixed_bits: assert property (@(posedge clk) disable iff (rst)
    rd_hit |=> cfg_rdata[`SCTL_B_ONE] && !cfg_rdata[`SCTL_B_ZERO_HI]
               && !cfg_rdata[`SCTL_B_ZERO_LO] && cfg_rdata[31:22] == '0)
    else $error("fixed bits read wrong");
  a_ro_write: assert property (@(posedge clk) disable iff (rst)
    wr_hit && !card_access && !socket_activity_flag |=> !socket_activity_flag)
    else $error("write changed activity flag");
  a_burst_write: assert property (@(posedge clk) disable iff (rst)
    wr_mid |=> read_burst_downstream_en == $past(cfg_wdata[`SCTL_B_BURST_DN]))
    else $error("downstream burst enable not written");
  a_pin_wake: assert property (@(posedge clk) disable iff (rst)
    wake_ring_pin_select |=> !wake_ring_pin_oe_n && wake_ring_pin_o == $past(pme_event))
    else $error("wake event not on pin");
  a_pin_float: assert property (@(posedge clk) disable iff (rst)
    !wake_ring_pin_select && !ring_output_enable |=> wake_ring_pin_oe_n)
    else $error("pin driven while disabled");
  a_ctx_keep: assert property (@(posedge clk) disable iff (rst)
    pme_enable && probe_active |=> card_probe_busy)
    else $error("context bit lost while wake armed");
  a_global_reset_n_only: assert property (@(posedge clk) disable iff (rst)
    !bus_rst_n_s && !wr_hit |=> $stable(read_burst_downstream_en)
                                && $stable(card_supply_protect_disable))
    else $error("bus reset cleared global field");
endmodule
`default_nettype wire

//--- tb/sctl_switch_model.sv
// Purpose: Power switch stand-in that ends the serial power stream.
// Assumes: Delay input is at least one cycle.
// Notes:   Done is a one-cycle pulse and is never sent without a request.
`timescale 1ns/100ps
`default_nettype none
module sctl_switch_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Stream request, length and end
  input  wire logic       pwr_change_req,
  input  wire logic [7:0] delay,
  output var  logic       stream_done
);
  logic [7:0] cnt_r;
  logic       busy_r;
  // A new request restarts the stream, so a stale done can never leak out
  always_ff @(posedge clk) begin
    stream_done <= 1'b0;
    if (rst) begin
      busy_r <= 1'b0;
      cnt_r  <= 8'h00;
    end else if (pwr_change_req) begin
      busy_r <= 1'b1;
      cnt_r  <= delay;
    end else if (busy_r) begin
      cnt_r <= cnt_r - 8'h01;
      if (cnt_r == 8'h01) begin
        busy_r      <= 1'b0;
        stream_done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/sctl_top_test.sv
// Purpose: Self-checking bench for the system control bank.
// Assumes: One 100 MHz clock; synchronous global reset.
// Notes:   Fixed seed, so every run repeats exactly.
`timescale 1ns/100ps
`default_nettype none
`include "sctl_regs.svh"
module sctl_top_test;
  logic        clk, rst, pci_bus_reset_n, pme_enable, cfg_rd, cfg_wr, card_access;
  logic        pwr_change_req, stream_done, stream_is_up, probe_active, legacy_5v_sel;
  logic        card_parity_err, pme_event, ring_indicate_output, ring_output_enable;
  logic        card_supply_protect_disable, read_burst_downstream_en, read_burst_upstream_en;
  logic        low_power_mode_en, id_regs_write_lock, card_parity_to_syserr_en;
  logic        clocks_always_on, wake_ring_pin_select, card_parity_syserr;
  logic        wake_ring_pin_o, wake_ring_pin_oe_n;
  logic [7:0]  cfg_addr, delay;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, sw, d, r;
  integer      seed = 27155;
  int          n_fail = 0;
  int          n_compared = 0;

  sctl_top u_dut (.clk, .rst, .pci_bus_reset_n, .pme_enable, .cfg_addr, .cfg_rd, .cfg_wr,
    .cfg_be, .cfg_wdata, .cfg_rdata, .card_access, .pwr_change_req, .stream_done,
    .stream_is_up, .probe_active, .legacy_5v_sel, .card_parity_err, .pme_event,
    .ring_indicate_output, .ring_output_enable, .card_supply_protect_disable,
    .read_burst_downstream_en, .read_burst_upstream_en, .low_power_mode_en,
    .id_regs_write_lock, .card_parity_to_syserr_en, .clocks_always_on,
    .wake_ring_pin_select, .card_parity_syserr, .wake_ring_pin_o, .wake_ring_pin_oe_n);
  sctl_switch_model u_sw (.clk, .rst, .pwr_change_req, .delay, .stream_done);

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic test_done;
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Only writable lanes move; lane 2 bits 20-16 are preserved by the caller
  function automatic logic [31:0] exp_wr(input logic [31:0] o, input logic [3:0] b,
                                         input logic [31:0] v);
    logic [31:0] m;
    m = {8'h00, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & 32'h003fc073;
    return (o & ~m) | (v & m);
  endfunction
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    cfg_addr <= a;
    cfg_rd   <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1 d = cfg_rdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
    @(posedge clk);
    cfg_addr  <= a;
    cfg_wr    <= 1'b1;
    cfg_be    <= b;
    cfg_wdata <= v;
    @(posedge clk);
    cfg_wr <= 1'b0;
    if (a == `SCTL_OFFSET) sw = exp_wr(sw, b, v);
  endtask
  // Read the register; bit 12 always one, upper bits outside this block
  task automatic chk_reg(input string n, input logic [31:0] st);
    rd(`SCTL_OFFSET);
    chk(n, d, (sw & 32'h003fc073) | 32'h00001000 | st);
  endtask
  task automatic chk_fields;
    chk("fields", {24'h0, card_supply_protect_disable, read_burst_downstream_en,
        read_burst_upstream_en, low_power_mode_en, id_regs_write_lock,
        card_parity_to_syserr_en, clocks_always_on, wake_ring_pin_select},
        {24'h0, sw[21], sw[15], sw[14], sw[6], sw[5], sw[4], sw[1], sw[0]});
  endtask
  // One power sequence; optional bus reset while settling
  task automatic pwr(input logic up, input logic br);
    int k;
    stream_is_up <= up;
    delay <= 8'd8 + 8'($random(seed) & 63);
    @(posedge clk);
    pwr_change_req <= 1'b1;
    @(posedge clk);
    pwr_change_req <= 1'b0;
    chk_reg("stream", 32'h800);
    k = 0;
    while (stream_done !== 1'b1 && k < 300) begin
      @(posedge clk);
      #1 k++;
    end
    chk_reg("settle", up ? 32'hc00 : 32'ha00);
    if (br) begin
      pme_enable <= 1'b1;
      probe_active <= 1'b1;
      pci_bus_reset_n <= 1'b0;
      repeat (6) @(posedge clk);
      chk_reg("ctx kept", 32'hd00);
      pme_enable <= 1'b0;
      repeat (4) @(posedge clk);
      chk_reg("ctx clr", 32'h800);
      pci_bus_reset_n <= 1'b1;
      probe_active <= 1'b0;
    end
    repeat (1950) @(posedge clk);
    chk_reg("late", br ? 32'h800 : (up ? 32'hc00 : 32'ha00));
    repeat (60) @(posedge clk);
    chk_reg("idle", 32'h0);
  endtask

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Run needs about 6500 cycles; cut off well beyond that
  initial begin
    #400000;
    n_fail++;
    test_done;
  end
  initial begin
    {rst, pci_bus_reset_n} = 2'b11;
    {pme_enable, cfg_rd, cfg_wr, card_access, pwr_change_req, stream_is_up} = '0;
    {probe_active, legacy_5v_sel, card_parity_err, pme_event} = '0;
    {ring_indicate_output, ring_output_enable, cfg_addr, cfg_be, cfg_wdata} = '0;
    delay = 8'h10;
    sw = `SCTL_RESET_VALUE;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk_reg("reset", 32'h0);
    chk_fields;
    // All-ones and all-zeros first, then random lanes and data
    for (int i = 0; i < 42; i++) begin
      r = (i < 2) ? {32{~i[0]}} : $random(seed);
      wr(`SCTL_OFFSET, (i < 2) ? 4'hf : 4'($random(seed)), {r[31:21], sw[20:16], r[15:0]});
      chk_reg("rand", 32'h0);
      chk_fields;
    end
    wr(8'h84, 4'hf, 32'hffffffff);
    rd(8'h84);
    chk("unmapped", d, 32'h0);
    chk_reg("after unmapped", 32'h0);
    @(posedge clk);
    card_access <= 1'b1;
    @(posedge clk);
    card_access <= 1'b0;
    chk_reg("active", 32'h2000);
    chk_reg("active clr", 32'h0);
    probe_active <= 1'b1;
    legacy_5v_sel <= 1'b1;
    repeat (3) @(posedge clk);
    chk_reg("probe", 32'h104);
    probe_active <= 1'b0;
    legacy_5v_sel <= 1'b0;
    repeat (3) @(posedge clk);
    chk_reg("probe off", 32'h0);
    pwr(1'b1, 1'b0);
    pwr(1'b0, 1'b0);
    pwr(1'b1, 1'b1);
    chk_fields;
    // Every pin select, ring enable, ring and wake level
    for (int i = 0; i < 16; i++) begin
      wr(`SCTL_OFFSET, 4'h1, {sw[31:1], i[3]});
      ring_output_enable <= i[2];
      ring_indicate_output <= i[1];
      pme_event <= i[0];
      repeat (3) @(posedge clk);
      #1 chk("pin oe_n", {31'h0, wake_ring_pin_oe_n}, {31'h0, ~(i[3] | i[2])});
      if (i[3] | i[2]) chk("pin", {31'h0, wake_ring_pin_o}, {31'h0, i[3] ? i[0] : i[1]});
    end
    for (int b = 0; b < 2; b++) begin
      wr(`SCTL_OFFSET, 4'h1, {sw[31:5], b[0], sw[3:0]});
      @(posedge clk);
      card_parity_err <= 1'b1;
      @(posedge clk);
      card_parity_err <= 1'b0;
      #1 chk("syserr", {31'h0, card_parity_syserr}, {31'h0, b[0]});
    end
    test_done;
  end
endmodule
`default_nettype wire
